/* shared/jsg_pkg.sv */
// constants and carrier types for the transmit guard
package jsg_pkg;
    // clock and bit-time reference
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_NS = 100;
    localparam int BIT_CYC = BIT_TIME_NS / CLK_PERIOD_NS;
    // noise filter: least negative pulse and longest positive excursion
    localparam int NEG_MIN_NS = 7;
    localparam int NEG_MIN_CYC_RAW =
        (NEG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NEG_MIN_CYC = (NEG_MIN_CYC_RAW < 1) ? 1 : NEG_MIN_CYC_RAW;
    localparam int POS_MAX_NS = 160;
    localparam int POS_MAX_CYC = POS_MAX_NS / CLK_PERIOD_NS;
    // heartbeat placement after the final transition, in bit times
    localparam int HB_DELAY_BITS = 8;
    localparam int HB_LEN_BITS = 8;
    localparam int HB_START_CYC = HB_DELAY_BITS * BIT_CYC;
    localparam int HB_END_CYC = (HB_DELAY_BITS + HB_LEN_BITS) * BIT_CYC;
    // jabber timing in milliseconds
    localparam int JAB_MS = 25;
    localparam int JAB_RESET_MS = 400;
    localparam int MS_NS = 1000000;
    localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
    // counter widths
    localparam int QUIET_W = 8;
    localparam int MS_TIMER_W = 10;
    localparam logic [QUIET_W-1:0] QUIET_MAX = 8'hff;

    // synchronised pin inputs travelling together
    typedef struct packed {
        logic tx_pair;
        logic supply_good;
        logic heartbeat_strap;
        logic external_jabber_input;
        logic collision_oscillator_input;
        logic collision_detect;
    } jsg_pins_t;
endpackage

/* rtl/jsg_ms_timer.sv */
// saturating tick counter used for the millisecond jabber intervals
`timescale 1ns/1ps
module jsg_ms_timer
    import jsg_pkg::*;
#(
    parameter int W = MS_TIMER_W,
    parameter logic [MS_TIMER_W-1:0] LIMIT = 10'h001
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic i_tick,
    output logic o_done
);
    logic [W-1:0] cnt_q; // elapsed ticks since last clear

    // count ticks while running, hold at the limit
    always_ff @(posedge i_clk) begin
        if (i_rst || i_clear) begin
            cnt_q <= '0;
        end else if (i_tick && cnt_q != LIMIT) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // done stays up until cleared; a clear wins over the tick
    always_ff @(posedge i_clk) begin
        if (i_rst || i_clear) begin
            o_done <= 1'b0;
        end else begin
            o_done <= (cnt_q == LIMIT);
        end
    end
endmodule

/* rtl/jsg_guard.sv */
// transmit guard: noise filter, tap gating, jabber and heartbeat
`timescale 1ns/1ps
module jsg_guard
    import jsg_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC // shorten in simulation
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_tx_pair,          // transmit pair level, 1 = positive
    input wire logic i_supply_good,      // high while supply above minimum
    input wire logic i_heartbeat_strap,  // high selects heartbeat
    input wire logic i_external_jabber_input,    // high disables tap
    input wire logic i_collision_oscillator_input, // high = tied to supply
    input wire logic i_collision_detect, // medium collision level
    output logic o_tap_transmit_output,  // data toward the tap driver
    output logic o_tap_drive,            // tap driver enable
    output logic o_collision_pair,       // 10 MHz collision-pair signal
    output logic o_jabber_fault          // jabber fault level
);
    jsg_pins_t raw; // pins gathered before the crossing
    jsg_pins_t meta_q; // first synchroniser stage, read only by stage two
    jsg_pins_t pin_q; // safe synchronised copy
    logic tx_prev_q; // previous tx level for edge finding
    logic tx_active_q; // a qualified transmission is in progress
    logic [QUIET_W-1:0] low_q; // consecutive low samples
    logic [QUIET_W-1:0] quiet_q; // cycles since the last transition
    logic hb_pend_q; // heartbeat window armed
    logic [3:0] div_q; // divider for the bit-time reference
    logic bit_tick; // one pulse each bit time
    logic osc_phase; // 10 MHz square wave
    logic [$clog2(MS_CYCLES+1)-1:0] ms_cnt_q; // millisecond prescaler
    logic ms_tick; // one pulse each millisecond
    logic jabber_q; // internal jabber fault
    logic jab_done; // jab time reached
    logic rst_done; // quiet reset period reached
    logic guard_off; // oscillator tie disables supervision
    logic tx_edge; // transition seen this cycle
    logic tx_start; // qualified start of a transmission
    logic tx_end; // long positive excursion ends transmission
    logic hb_window; // heartbeat burst window
    logic cp_want; // collision pair should oscillate
    logic tap_ok; // tap may be driven

    assign raw = '{tx_pair: i_tx_pair, supply_good: i_supply_good,
                   heartbeat_strap: i_heartbeat_strap,
                   external_jabber_input: i_external_jabber_input,
                   collision_oscillator_input: i_collision_oscillator_input,
                   collision_detect: i_collision_detect};

    // two-stage synchroniser for every pin; idle tx pair rests high
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= '0;
            pin_q <= '0;
            meta_q.tx_pair <= 1'b1;
            pin_q.tx_pair <= 1'b1;
        end else begin
            meta_q <= raw;
            pin_q <= meta_q;
        end
    end

    // bit-time divider gives both the bit tick and the 10 MHz wave
    always_ff @(posedge i_clk) begin
        if (i_rst || bit_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    // wrap pulse is the bit-time enable; wave is high in the first half
    // so the collision pair keeps an even duty cycle at any phase
    assign bit_tick = (div_q == 4'(BIT_CYC - 1));
    assign osc_phase = (div_q < 4'(BIT_CYC / 2));

    // millisecond prescaler made of the same reference
    always_ff @(posedge i_clk) begin
        if (i_rst || ms_tick) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= ms_cnt_q + 1'b1;
        end
    end
    assign ms_tick = (ms_cnt_q == ($bits(ms_cnt_q))'(MS_CYCLES - 1));

    assign tx_edge = (pin_q.tx_pair != tx_prev_q);
    assign guard_off = pin_q.collision_oscillator_input;

    // run lengths of low level and of quiet time, both saturating
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_prev_q <= 1'b1;
            low_q <= '0;
            quiet_q <= QUIET_MAX;
        end else begin
            tx_prev_q <= pin_q.tx_pair;
            if (pin_q.tx_pair) begin
                low_q <= '0;
            end else if (low_q != QUIET_MAX) begin
                low_q <= low_q + 1'b1;
            end
            if (tx_edge) begin
                quiet_q <= '0;
            end else if (quiet_q != QUIET_MAX) begin
                quiet_q <= quiet_q + 1'b1;
            end
        end
    end

    // a start needs a negative pulse of least width; the idle level
    // must persist past the longest excursion to end the frame
    assign tx_start = !tx_active_q && !pin_q.tx_pair
                      && (low_q >= QUIET_W'(NEG_MIN_CYC - 1));
    assign tx_end = tx_active_q && pin_q.tx_pair
                    && (quiet_q >= QUIET_W'(POS_MAX_CYC));

    // transmission state; end detection sits well inside 1 us
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_active_q <= 1'b0;
        end else if (tx_start) begin
            tx_active_q <= 1'b1;
        end else if (tx_end) begin
            tx_active_q <= 1'b0;
        end
    end

    // heartbeat arming: armed at frame end, dropped on a new start
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hb_pend_q <= 1'b0;
        end else if (tx_start) begin
            hb_pend_q <= 1'b0;
        end else if (tx_end) begin
            hb_pend_q <= pin_q.heartbeat_strap && !guard_off;
        end else if (quiet_q >= QUIET_W'(HB_END_CYC)) begin
            hb_pend_q <= 1'b0;
        end
    end

    // window measured from the final transition, not from tx_end
    assign hb_window = hb_pend_q && !tx_active_q
                       && quiet_q >= QUIET_W'(HB_START_CYC)
                       && quiet_q < QUIET_W'(HB_END_CYC);

    // jab timer runs only while the tap is driven, restarts per frame
    jsg_ms_timer #(
        .W(MS_TIMER_W),
        .LIMIT(MS_TIMER_W'(JAB_MS))
    ) u_jab (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clear(!o_tap_drive || guard_off),
        .i_tick(ms_tick),
        .o_done(jab_done)
    );

    // reset period needs continuous transmit silence
    jsg_ms_timer #(
        .W(MS_TIMER_W),
        .LIMIT(MS_TIMER_W'(JAB_RESET_MS))
    ) u_unjab (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clear(tx_active_q || !jabber_q),
        .i_tick(ms_tick),
        .o_done(rst_done)
    );

    // jabber fault: the tie clears it; otherwise setting wins over clearing in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_rst || guard_off) begin
            jabber_q <= 1'b0;
        end else if (jab_done) begin
            jabber_q <= 1'b1;
        end else if (rst_done) begin
            jabber_q <= 1'b0;
        end
    end

    // tap gating: supply, jabber and external jabber each veto
    assign tap_ok = pin_q.supply_good
                    && !jabber_q
                    && !pin_q.external_jabber_input;

    // collision-pair demand; the oscillator tie silences all of it
    assign cp_want = !guard_off
                     && (hb_window
                         || jabber_q
                         || pin_q.external_jabber_input
                         || pin_q.collision_detect);

    // registered outputs
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_tap_drive <= 1'b0;
            o_tap_transmit_output <= 1'b1;
            o_collision_pair <= 1'b0;
            o_jabber_fault <= 1'b0;
        end else begin
            o_tap_drive <= tx_active_q && tap_ok;
            o_tap_transmit_output <= pin_q.tx_pair;
            o_collision_pair <= cp_want && osc_phase;
            o_jabber_fault <= jabber_q;
        end
    end
endmodule

/* dv/jsg_dte_model.sv */
// terminal-side model: idle high, 10 MHz square while sending
`timescale 1ns/1ps
module jsg_dte_model (
    input wire logic i_clk,
    input wire logic i_send,
    output logic o_tx
);
    logic [2:0] ph_q; // half bit counter, five clocks each
    // first edge of a frame goes negative, idle returns high
    always_ff @(posedge i_clk) begin
        ph_q <= (ph_q == 3'h4 || !i_send) ? 3'h0 : ph_q + 3'h1;
        if (!i_send) o_tx <= 1'b1;
        else if (ph_q == 3'h0) o_tx <= !o_tx;
    end
endmodule

/* dv/jsg_guard_monitor.sv */
// port-level checks for the transmit guard
`timescale 1ns/1ps
module jsg_guard_monitor #(
    parameter int MS_CYCLES = 10
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_tx_pair,
    input wire logic i_supply_good,
    input wire logic i_heartbeat_strap,
    input wire logic i_external_jabber_input,
    input wire logic i_collision_oscillator_input,
    input wire logic i_collision_detect,
    input wire logic o_tap_transmit_output,
    input wire logic o_tap_drive,
    input wire logic o_collision_pair,
    input wire logic o_jabber_fault
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic osc = i_collision_oscillator_input; // tie silences collision pair and jabber
    logic [31:0] run_q; // consecutive tap drive cycles
    logic [7:0] idle_q; // consecutive high cycles on the pair
    // run length only bounded while the jabber is enabled
    always_ff @(posedge i_clk) begin
        if (i_rst || !o_tap_drive || osc) run_q <= 32'h0;
        else run_q <= run_q + 32'h1;
    end
    // saturate so a long idle never wraps below the limit
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_tx_pair) idle_q <= 8'h0;
        else if (idle_q != 8'hff) idle_q <= idle_q + 8'h1;
    end
    sequence s_ext;
        (i_external_jabber_input && !osc)[*5];
    endsequence
    sequence s_half;
        ##5 !o_collision_pair;
    endsequence
    a_supply_off: assert property (
        (!i_supply_good)[*5] |-> !o_tap_drive)
        else $error("tap driven while supply low");
    a_fault_isolates: assert property (
        o_jabber_fault[*2] |-> !o_tap_drive)
        else $error("tap driven during jabber fault");
    a_jab_limit: assert property (run_q <= 26 * MS_CYCLES + 4)
        else $error("tap drive outlasted jab time");
    a_osc_silent: assert property (osc[*5] |-> !o_collision_pair)
        else $error("collision pair active with oscillator tie");
    a_ext_drive: assert property (s_ext |-> !o_tap_drive)
        else $error("tap driven during external jabber");
    a_ext_coll: assert property (s_ext |-> ##[0:10] o_collision_pair)
        else $error("no collision pair on external jabber");
    a_coll_detect: assert property ((i_collision_detect && !osc)[*5]
        |-> ##[0:10] o_collision_pair) else $error("collision not reported");
    a_idle_release: assert property (
        idle_q >= 8'h1c |-> !o_tap_drive)
        else $error("tap driven on idle pair");
    a_coll_square: assert property (
        $rose(o_collision_pair) |-> s_half)
        else $error("collision pair high too long");
endmodule
bind jsg_guard jsg_guard_monitor #(.MS_CYCLES(MS_CYCLES)) mon (
    .i_clk(i_clk), .i_rst(i_rst), .i_tx_pair(i_tx_pair),
    .i_supply_good(i_supply_good), .i_heartbeat_strap(i_heartbeat_strap),
    .i_external_jabber_input(i_external_jabber_input),
    .i_collision_oscillator_input(i_collision_oscillator_input),
    .i_collision_detect(i_collision_detect),
    .o_tap_transmit_output(o_tap_transmit_output),
    .o_tap_drive(o_tap_drive), .o_collision_pair(o_collision_pair),
    .o_jabber_fault(o_jabber_fault)
);

/* dv/tb_top.sv */
// self-checking bench for the transmit guard
`timescale 1ns/1ps
module tb_top;
    import jsg_pkg::*;
    logic i_clk = 1'b0, i_rst = 1'b1, send = 1'b0, tx;
    logic sup = 1'b1, strap = 1'b1, ext = 1'b0, osc = 1'b0, cd = 1'b0;
    logic tap, drv, cp, jf; // guard outputs
    logic [2:0] tx_d = 3'h7; // pin level at the last three edges
    // pin history: tap data trails the pin by the two sync stages and
    // the output register
    always @(posedge i_clk) begin
        tx_d <= {tx_d[1:0], tx};
    end
    int failures = 0, n_compared = 0, cyc_n = 0;
    always #5 i_clk = ~i_clk;
    jsg_dte_model dte (.i_clk(i_clk), .i_send(send), .o_tx(tx));
    // millisecond prescale shortened to ten clocks
    jsg_guard #(.MS_CYCLES(10)) uut (.i_clk(i_clk), .i_rst(i_rst),
        .i_tx_pair(tx), .i_supply_good(sup), .i_heartbeat_strap(strap),
        .i_external_jabber_input(ext), .i_collision_oscillator_input(osc),
        .i_collision_detect(cd), .o_tap_transmit_output(tap),
        .o_tap_drive(drv), .o_collision_pair(cp), .o_jabber_fault(jf));
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // highs on the collision pair over n cycles
    task automatic cnt_cp(input int n, output logic [15:0] c);
        c = 16'h0;
        repeat (n) begin
            @(negedge i_clk);
            c += {15'h0, cp};
        end
    endtask
    task automatic finish_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // two frames with a short gap, then heartbeat per strap
    task automatic t_frame(input logic s);
        logic [15:0] c;
        strap = s;
        send = 1'b1;
        cyc(40);
        repeat (10) begin
            cyc(1);
            chk(tap, {15'h0, tx_d[2]});
        end
        chk(drv, 16'h1);
        send = 1'b0;
        // gap long enough for the heartbeat burst to be running
        cyc(110);
        send = 1'b1;
        cyc(10);
        cnt_cp(50, c);
        chk(c, 16'h0);
        send = 1'b0;
        cnt_cp(70, c);
        chk(c, 16'h0);
        cnt_cp(130, c);
        chk(c, s ? 16'h28 : 16'h0);
        chk(drv, 16'h0);
    endtask
    task automatic t_supply;
        sup = 1'b0;
        send = 1'b1;
        cyc(30);
        chk(drv, 16'h0);
        sup = 1'b1;
        cyc(10);
        chk(drv, 16'h1);
        send = 1'b0;
        cyc(200);
    endtask
    task automatic t_ext;
        logic [15:0] c;
        ext = 1'b1;
        send = 1'b1;
        cyc(10);
        cnt_cp(20, c);
        chk(c, 16'ha);
        chk(drv, 16'h0);
        ext = 1'b0;
        cyc(10);
        chk(drv, 16'h1);
        send = 1'b0;
        cyc(200);
    endtask
    task automatic t_coll;
        logic [15:0] c;
        cd = 1'b1;
        cyc(10);
        cnt_cp(40, c);
        chk(c, 16'h14);
        cd = 1'b0;
        cyc(10);
        cnt_cp(20, c);
        chk(c, 16'h0);
    endtask
    task automatic t_jabber;
        int n;
        logic [15:0] c;
        n = 0;
        send = 1'b1;
        while (jf !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        chk(16'(n >= 235 && n <= 280), 16'h1);
        cnt_cp(20, c);
        chk(c, 16'ha);
        chk(drv, 16'h0);
        send = 1'b0;
        cyc(3850);
        chk(jf, 16'h1);
        cyc(300);
        chk(jf, 16'h0);
    endtask
    // tie: long frame, collision and end of frame all silent
    task automatic t_osc;
        logic [15:0] c;
        osc = 1'b1;
        cd = 1'b1;
        send = 1'b1;
        cyc(400);
        chk(jf, 16'h0);
        chk(drv, 16'h1);
        send = 1'b0;
        cd = 1'b0;
        cnt_cp(200, c);
        chk(c, 16'h0);
        osc = 1'b0;
    endtask
    // hang guard, well above the expected run length
    always @(posedge i_clk) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            failures++;
            finish_test;
        end
    end
    initial begin
        cyc(4);
        chk(tap, 16'h1);
        i_rst = 1'b0;
        cyc(5);
        t_frame(1'b0);
        t_frame(1'b1);
        t_supply;
        t_ext;
        t_coll;
        t_jabber;
        t_osc;
        finish_test;
    end
endmodule
